// ==== stp_defines.vh ====
// Purpose: Constants for the serial terminal port
// Assumes: 40 MHz clock
// Notes: Divisors are clock cycles per bit
`ifndef STP_DEFINES_VH
`define STP_DEFINES_VH
`define STP_CLK_HZ 40000000
`define STP_DIV_110 (`STP_CLK_HZ / 110)
`define STP_DIV_150 (`STP_CLK_HZ / 150)
`define STP_DIV_300 (`STP_CLK_HZ / 300)
`define STP_DIV_600 (`STP_CLK_HZ / 600)
`define STP_DIV_1200 (`STP_CLK_HZ / 1200)
`define STP_DIV_2400 (`STP_CLK_HZ / 2400)
`define STP_DIV_4800 (`STP_CLK_HZ / 4800)
`define STP_DIV_9600 (`STP_CLK_HZ / 9600)
`define STP_BAUD_DEFAULT 3'h7
`define STP_BAUD_600 3'h3
`define STP_STOP_1 2'h0
`define STP_STOP_15 2'h1
`define STP_STOP_2 2'h2
`define STP_DATA_BITS 4'h8
`define STP_FIFO_WIDTH 8
`define STP_FIFO_DEPTH 32
`define STP_FIFO_AW 5
`define STP_RX_MARGIN 6'h04
`endif

// ==== stp_fifo.v ====
// Purpose: Synchronous FIFO with valid and ready on both sides
// Assumes: One clock, clock enable freezes state
// Notes: Depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module stp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire mclk,
    input wire rst_n,
    input wire clkEn,
    input wire [WIDTH-1:0] inData,
    input wire inValid,
    output wire inReady,
    output wire [WIDTH-1:0] outData,
    output wire outValid,
    input wire outReady,
    output reg [AW:0] level
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr;
    reg [AW-1:0] rdPtr;
    wire doWr;
    wire doRd;
    assign inReady = (level != DEPTH[AW:0]);
    assign outValid = (level != {(AW+1){1'b0}});
    assign outData = mem[rdPtr];
    assign doWr = clkEn && inValid && inReady;
    assign doRd = clkEn && outValid && outReady;
    always @(posedge mclk) begin
        if (doWr) begin
            mem[wrPtr] <= inData;
        end
    end
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            level <= {(AW+1){1'b0}};
        end else begin
            if (doWr) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doRd) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (doWr && !doRd) begin
                level <= level + 1'b1;
            end else if (doRd && !doWr) begin
                level <= level - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== stp_serial_port.v ====
// Purpose: Serial terminal port, 8 data bits, no parity, 1, 1.5 or 2 stop bits, with DTR/DSR handshake
// Assumes: Inputs synchronous to mclk; user side via valid/ready
// Notes: Receive data passes a 32 word FIFO
`timescale 1ns/1ps
`default_nettype none
`include "stp_defines.vh"
module stp_serial_port (
    input wire mclk,
    input wire rst_n,
    input wire clkEn,
    input wire loopMode,
    input wire [2:0] baudSel,
    input wire [1:0] stopSel,
    input wire [2:0] baudCap,
    input wire rxLine,
    input wire peerReady,
    input wire clearToSend,
    output reg txLine,
    output reg termReady,
    output reg reqToSend,
    output reg reqToSendOe_n,
    input wire [7:0] txData,
    input wire txValid,
    output reg txReady,
    output reg [7:0] rxData,
    output reg rxValid,
    input wire rxTake,
    output reg rxOverrun
);
    localparam S_IDLE = 2'h0;
    localparam S_START = 2'h1;
    localparam S_DATA = 2'h2;
    localparam S_STOP = 2'h3;

    function [19:0] bitDiv;
        input [2:0] sel;
        reg [31:0] full;
        begin
            case (sel)
                3'h0: full = `STP_DIV_110;
                3'h1: full = `STP_DIV_150;
                3'h2: full = `STP_DIV_300;
                3'h3: full = `STP_DIV_600;
                3'h4: full = `STP_DIV_1200;
                3'h5: full = `STP_DIV_2400;
                3'h6: full = `STP_DIV_4800;
                default: full = `STP_DIV_9600;
            endcase
            bitDiv = full[19:0];
        end
    endfunction

    function cntDone;
        input [19:0] cnt;
        input [19:0] lim;
        begin
            cntDone = (cnt == lim - 20'h00001);
        end
    endfunction

    function [2:0] capRate;
        input [2:0] sel;
        input [2:0] cap;
        begin
            capRate = (sel > cap) ? cap : sel;
        end
    endfunction

    wire [2:0] effBaud;
    assign effBaud = capRate(baudSel, baudCap);
    wire [19:0] div;
    assign div = bitDiv(effBaud);
    wire [19:0] halfDiv;
    assign halfDiv = {1'b0, div[19:1]};
    wire [19:0] stopLen;
    assign stopLen = (stopSel == `STP_STOP_15) ? (div + halfDiv) :
                     (stopSel == `STP_STOP_2) ? {div[18:0], 1'b0} : div;
    // handshake only at 600 and above
    wire hwHs;
    assign hwHs = (effBaud >= `STP_BAUD_600);

    // Transmitter
    reg [1:0] txState;
    reg [19:0] txCnt;
    reg [2:0] txBit;
    reg [7:0] txShift;
    reg [19:0] txDiv;
    reg [19:0] txStopLen;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            txState <= S_IDLE;
            txCnt <= 20'h00000;
            txBit <= 3'h0;
            txShift <= 8'h00;
            txDiv <= 20'h00000;
            txStopLen <= 20'h00000;
            txLine <= 1'b1;
            txReady <= 1'b0;
        end else if (clkEn) begin
            case (txState)
                S_IDLE: begin
                    txLine <= 1'b1;
                    if (txValid && txReady) begin
                        txShift <= txData;
                        txDiv <= div;
                        txStopLen <= stopLen;
                        txReady <= 1'b0;
                        txLine <= 1'b0;
                        txCnt <= 20'h00000;
                        txState <= S_START;
                    end else begin
                        txReady <= (!hwHs || peerReady);
                    end
                end
                S_START: begin
                    if (cntDone(txCnt, txDiv)) begin
                        txCnt <= 20'h00000;
                        txLine <= txShift[0];
                        txBit <= 3'h0;
                        txState <= S_DATA;
                    end else begin
                        txCnt <= txCnt + 20'h00001;
                    end
                end
                S_DATA: begin
                    if (cntDone(txCnt, txDiv)) begin
                        txCnt <= 20'h00000;
                        if (txBit == 3'h7) begin
                            txLine <= 1'b1;
                            txState <= S_STOP;
                        end else begin
                            txBit <= txBit + 3'h1;
                            txShift <= {1'b0, txShift[7:1]};
                            txLine <= txShift[1];
                        end
                    end else begin
                        txCnt <= txCnt + 20'h00001;
                    end
                end
                S_STOP: begin
                    if (txCnt >= txStopLen - 20'h00001) begin
                        txCnt <= 20'h00000;
                        txState <= S_IDLE;
                    end else begin
                        txCnt <= txCnt + 20'h00001;
                    end
                end
                default: begin
                    txState <= S_IDLE;
                end
            endcase
        end
    end

    // Receiver
    reg [1:0] rxState;
    reg [19:0] rxCnt;
    reg [2:0] rxBit;
    reg [7:0] rxShift;
    reg [19:0] rxDiv;
    reg rxPush;
    reg [7:0] rxWord;
    wire fifoInReady;
    wire [7:0] fifoOutData;
    wire fifoOutValid;
    wire [5:0] fifoLevel;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rxState <= S_IDLE;
            rxCnt <= 20'h00000;
            rxBit <= 3'h0;
            rxShift <= 8'h00;
            rxDiv <= 20'h00000;
            rxPush <= 1'b0;
            rxWord <= 8'h00;
            rxOverrun <= 1'b0;
        end else if (clkEn) begin
            rxPush <= 1'b0;
            case (rxState)
                S_IDLE: begin
                    if (!rxLine) begin
                        rxCnt <= 20'h00000;
                        rxDiv <= div;
                        rxState <= S_START;
                    end
                end
                S_START: begin
                    if (cntDone(rxCnt, {1'b0, rxDiv[19:1]})) begin
                        rxCnt <= 20'h00000;
                        rxBit <= 3'h0;
                        rxState <= rxLine ? S_IDLE : S_DATA;
                    end else begin
                        rxCnt <= rxCnt + 20'h00001;
                    end
                end
                S_DATA: begin
                    if (cntDone(rxCnt, rxDiv)) begin
                        rxCnt <= 20'h00000;
                        rxShift <= {rxLine, rxShift[7:1]};
                        rxBit <= rxBit + 3'h1;
                        if (rxBit == 3'h7) begin
                            rxState <= S_STOP;
                        end
                    end else begin
                        rxCnt <= rxCnt + 20'h00001;
                    end
                end
                S_STOP: begin
                    if (cntDone(rxCnt, rxDiv)) begin
                        rxCnt <= 20'h00000;
                        rxState <= S_IDLE;
                        if (rxLine) begin
                            if (fifoInReady) begin
                                rxWord <= rxShift;
                                rxPush <= 1'b1;
                            end else begin
                                rxOverrun <= 1'b1;
                            end
                        end
                    end else begin
                        rxCnt <= rxCnt + 20'h00001;
                    end
                end
                default: begin
                    rxState <= S_IDLE;
                end
            endcase
        end
    end

    wire popFifo = fifoOutValid && (!rxValid || rxTake);

    stp_fifo #(
        .WIDTH(`STP_FIFO_WIDTH),
        .DEPTH(`STP_FIFO_DEPTH),
        .AW(`STP_FIFO_AW)
    ) rxFifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .inData(rxWord),
        .inValid(rxPush),
        .inReady(fifoInReady),
        .outData(fifoOutData),
        .outValid(fifoOutValid),
        .outReady(popFifo),
        .level(fifoLevel)
    );

    // Receive handshake towards the user side
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rxData <= 8'h00;
            rxValid <= 1'b0;
        end else if (clkEn) begin
            if (popFifo) begin
                rxData <= fifoOutData;
                rxValid <= 1'b1;
            end else if (rxTake) begin
                rxValid <= 1'b0;
            end
        end
    end

    // Highest level at which ready may still stand
    wire [5:0] rxLimit;
    assign rxLimit = 6'h20 - `STP_RX_MARGIN;

    // Handshake pins
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            termReady <= 1'b0;
            reqToSend <= 1'b0;
            reqToSendOe_n <= 1'b1;
        end else if (clkEn) begin
            termReady <= !hwHs || (fifoLevel <= rxLimit);
            reqToSend <= !loopMode;
            reqToSendOe_n <= loopMode;
        end
    end
endmodule
`default_nettype wire

// ==== stp_port_checker.sv ====
// Purpose: Pin level assertions for the serial terminal port
// Assumes: Bound to stp_serial_port, one clock
// Notes: Handshake counts as active at rate code 3 and up
`timescale 1ns/1ps
`default_nettype none
module stp_port_checker (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic loopMode,
    input wire logic [2:0] baudSel,
    input wire logic [2:0] baudCap,
    input wire logic peerReady,
    input wire logic txValid,
    input wire logic txLine,
    input wire logic txReady,
    input wire logic termReady,
    input wire logic reqToSend,
    input wire logic reqToSendOe_n,
    input wire logic rxValid
);
    wire logic hs = ((baudSel < baudCap) ? baudSel : baudCap) >= 3'h3;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_rts_voltage: assert property (clkEn && !loopMode |=> reqToSend && !reqToSendOe_n)
        else $error("rts not driven in voltage mode");
    a_loop_rts_off: assert property (clkEn && loopMode |=> reqToSendOe_n)
        else $error("rts driven in loop mode");
    a_tx_start: assert property (clkEn && txValid && txReady |=> !txLine)
        else $error("no start bit after take");
    a_tx_busy: assert property (clkEn && txValid && txReady |=> !txReady [*8])
        else $error("ready during frame");
    a_idle_high: assert property (txReady |-> txLine)
        else $error("line not idle while ready");
    a_dsr_hold: assert property ((hs && !peerReady && clkEn) [*2] |-> !txReady)
        else $error("ready while peer busy");
    a_dtr_slow: assert property ((!hs && clkEn) [*2] |-> termReady)
        else $error("dtr low at slow rate");
    a_dtr_empty: assert property ((!rxValid && clkEn) [*3] |-> termReady)
        else $error("dtr low with empty buffer");
endmodule
bind stp_serial_port stp_port_checker stp_port_checker_inst (.mclk, .rst_n, .clkEn,
    .loopMode, .baudSel, .baudCap, .peerReady, .txValid, .txLine, .txReady, .termReady,
    .reqToSend, .reqToSendOe_n, .rxValid);
`default_nettype wire

// ==== stp_peer.sv ====
// Purpose: Attached terminal model, sends 8N frames with halves/2 stop bits and decodes 8N1 frames
// Assumes: div set to clock cycles per bit
// Notes: Received bytes collect in got
`timescale 1ns/1ps
`default_nettype none
module stp_peer (
    input wire logic mclk,
    input wire logic txLine,
    input wire logic holdOff,
    output logic rxLine,
    output wire logic peerReady
);
    integer div = 4166;
    integer i;
    logic [7:0] b;
    logic [7:0] got[$];
    assign peerReady = !holdOff;
    initial rxLine = 1'b1;
    task automatic send_char(input logic [7:0] c, input integer halves);
        logic [8:0] f;
        f = {c, 1'b0};
        for (int k = 0; k < 9; k++) begin
            rxLine <= f[k];
            repeat (div) @(negedge mclk);
        end
        rxLine <= 1'b1;
        repeat (div * halves / 2) @(negedge mclk);
    endtask
    always begin
        @(negedge txLine);
        repeat (div / 2) @(posedge mclk);
        for (i = 0; i < 8; i++) begin
            repeat (div) @(posedge mclk);
            b[i] = txLine;
        end
        repeat (div) @(posedge mclk);
        if (txLine) got.push_back(b);
    end
endmodule
`default_nettype wire

// ==== stp_serial_terminal_port_bench.sv ====
// Purpose: Self checking bench for the serial terminal port
// Assumes: 40 MHz clock, frames at 9600 baud
// Notes: Queues hold the bytes each side should see
`timescale 1ns/1ps
`default_nettype none
module stp_serial_terminal_port_bench;
    logic mclk = 1'b0, rst_n, clkEn, loopMode, clearToSend, txValid, rxTake, holdOff;
    logic [2:0] baudSel, baudCap;
    logic [1:0] stopSel;
    logic [7:0] txData, rxData;
    wire logic txLine, rxLine, peerReady;
    logic termReady, reqToSend, reqToSendOe_n, txReady, rxValid, rxOverrun;
    logic [7:0] txExp[$], rxExp[$];
    integer seed = 32'hae29, num_errors = 0, checked = 0;
    integer cyc = 0, takeCyc = 0;
    stp_serial_port stp_serial_port_inst (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
        .loopMode(loopMode), .baudSel(baudSel), .stopSel(stopSel), .baudCap(baudCap),
        .rxLine(rxLine), .peerReady(peerReady), .clearToSend(clearToSend), .txLine(txLine),
        .termReady(termReady), .reqToSend(reqToSend), .reqToSendOe_n(reqToSendOe_n),
        .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData),
        .rxValid(rxValid), .rxTake(rxTake), .rxOverrun(rxOverrun));
    stp_peer stp_peer_inst (.mclk(mclk), .txLine(txLine), .holdOff(holdOff),
        .rxLine(rxLine), .peerReady(peerReady));
    always #12.5 mclk = ~mclk;
    always @(negedge mclk) clearToSend <= $random(seed);
    always @(posedge mclk) cyc <= cyc + 1;
    task report_and_stop;
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task cmp_count(input string what, input integer exp, input integer got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task put_tx(input logic [7:0] c);
        int n;
        txData = c;
        txValid = 1'b1;
        for (n = 0; n < 5000 && txReady !== 1'b1; n++) @(negedge mclk);
        takeCyc = cyc;
        @(negedge mclk);
        txValid = 1'b0;
    endtask
    task frame(input integer halves);
        logic [7:0] a, r;
        int n;
        integer expCyc;
        a = $random(seed);
        r = $random(seed);
        txExp.push_back(a);
        rxExp.push_back(r);
        fork
            put_tx(a);
            stp_peer_inst.send_char(r, halves);
        join
        for (n = 0; n < 100 && rxValid !== 1'b1; n++) @(negedge mclk);
        cmp("rxValid", 8'h01, rxValid);
        cmp("rxData", rxExp.pop_front(), rxData);
        rxTake = 1'b1;
        @(negedge mclk);
        rxTake = 1'b0;
        for (n = 0; n < 5000 && stp_peer_inst.got.size() == 0; n++) @(negedge mclk);
        cmp("txByte", txExp.pop_front(), stp_peer_inst.got.size() ? stp_peer_inst.got.pop_front() : 8'hXX);
        expCyc = 9 * stp_peer_inst.div + stp_peer_inst.div * halves / 2 + 2;
        for (n = 0; n < 50000 && txReady !== 1'b1; n++) @(negedge mclk);
        cmp_count("txFrameCycles", expCyc, cyc - takeCyc);
    endtask
    initial begin
        #(96000 * 25);
        num_errors++;
        report_and_stop;
    end
    initial begin
        rst_n = 1'b0;
        clkEn = 1'b1;
        loopMode = 1'b0;
        clearToSend = 1'b0;
        baudSel = 3'h7;
        baudCap = 3'h7;
        stopSel = 2'h1;
        txData = 8'h00;
        txValid = 1'b0;
        rxTake = 1'b0;
        holdOff = 1'b0;
        repeat (8) @(negedge mclk);
        cmp("txLine", 8'h01, txLine);
        cmp("termReady", 8'h00, termReady);
        cmp("rtsOe_n", 8'h01, reqToSendOe_n);
        rst_n = 1'b1;
        repeat (3) @(negedge mclk);
        cmp("rts", 8'h01, reqToSend);
        cmp("rtsOe_n", 8'h00, reqToSendOe_n);
        cmp("termReady", 8'h01, termReady);
        cmp("txReady", 8'h01, txReady);
        clkEn = 1'b0;
        holdOff = 1'b1;
        repeat (4) @(negedge mclk);
        cmp("txReady", 8'h01, txReady);
        clkEn = 1'b1;
        repeat (4) @(negedge mclk);
        cmp("txReady", 8'h00, txReady);
        baudCap = 3'h2;
        repeat (3) @(negedge mclk);
        cmp("txReady", 8'h01, txReady);
        cmp("termReady", 8'h01, termReady);
        baudCap = 3'h7;
        repeat (3) @(negedge mclk);
        fork
            begin
                repeat (200) @(negedge mclk);
                holdOff = 1'b0;
            end
        join_none
        frame(3);
        $display("test 1 done");
        loopMode = 1'b1;
        stopSel = 2'h2;
        repeat (3) @(negedge mclk);
        cmp("rtsOe_n", 8'h01, reqToSendOe_n);
        frame(4);
        cmp("rxOverrun", 8'h00, rxOverrun);
        $display("test 2 done");
        report_and_stop;
    end
endmodule
`default_nettype wire
